/* hw/cycle_oscillator.sv */
// Jittered cycle oscillator: one-cycle start pulse and max duty window.
// Assumes the system clock named in the package; no other timing source.
`timescale 1ns/1ps
`default_nettype none
module cycle_oscillator (
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic cycle_start,
  output logic max_duty_window
);
  import switch_ctrl_pkg::*;

  logic [PER_W-1:0] cnt_q;
  logic [PER_W-1:0] period_q;
  logic [PER_W-1:0] tri_q;
  logic up_q;
  logic [15:0] mod_cnt_q;
  logic wrap;

  assign wrap = (cnt_q == period_q - PER_W'(1));

  // ----------------------------------------------------------------
  // Triangle modulation of the period
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mod_cnt_q <= 16'h0000;
      tri_q <= '0;
      up_q <= 1'b1;
    end else if (mod_cnt_q == JIT_STEP_CYCLES - 16'h0001) begin
      mod_cnt_q <= 16'h0000;
      if (up_q) begin
        tri_q <= tri_q + PER_W'(1);
        if (tri_q == JIT_SPAN - PER_W'(1)) up_q <= 1'b0;
      end else begin
        tri_q <= tri_q - PER_W'(1);
        if (tri_q == PER_W'(1)) up_q <= 1'b1;
      end
    end else begin
      mod_cnt_q <= mod_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  // New period taken only at wrap, so a cycle never changes length midway
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      period_q <= PERIOD_NOM;
    end else if (wrap) begin
      cnt_q <= '0;
      period_q <= PERIOD_FAST + tri_q;
    end else begin
      cnt_q <= cnt_q + PER_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cycle_start <= 1'b0;
      max_duty_window <= 1'b0;
    end else begin
      cycle_start <= wrap;
      max_duty_window <= wrap || (cnt_q + PER_W'(1) < MAX_DUTY_CYCLES);
    end
  end

  chk_period_band: assert property (@(posedge sys_clk) disable iff (!reset_n)
    period_q >= PERIOD_FAST && period_q <= PERIOD_SLOW)
    else $error("oscillator period outside jitter band");
  chk_start_window: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cycle_start |-> max_duty_window ##1 !cycle_start)
    else $error("cycle start without open duty window");

endmodule
`default_nettype wire

/* hw/on_off_switch_cycle_controller.sv */
// On/off cycle-skipping controller for an integrated power switch.
// Assumes analog comparators deliver synchronous flags on the sys_clk domain.
//
// Overview of operation
// - Oscillator averages 200 kHz, start and window
// - Period jitters 16 kHz pp at 1.5 kHz
// - Feedback enable low when current above threshold
// - Cycle start samples enable, decides conduction
// - Enable changes ignored after cycle start
// - Current limit ends pulse for the cycle
// - Current limit ignored during turn-on blanking
// - Under-voltage lockout with separate hysteresis flags
// - Thermal shutdown until cooled flag shows
// - Restart counter cleared while feedback enables, outside the off phase
// - No enable for 30 ms disables 650 ms
// - Restart alternates until feedback resumes
// - Supply charging only while switch off
`timescale 1ns/1ps
`default_nettype none
module on_off_switch_cycle_controller #(
  parameter int unsigned AR_ON_CYCLES = switch_ctrl_pkg::AR_ON_CYCLES_NOM,
  parameter int unsigned AR_OFF_CYCLES = switch_ctrl_pkg::AR_OFF_CYCLES_NOM
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic feedback_over_threshold,
  input wire logic current_limit,
  input wire switch_ctrl_pkg::protect_flags_t prot_flags,
  output logic feedback_enable,
  output logic power_switch_on,
  output logic supply_charge_en,
  output logic max_duty_window,
  output logic undervoltage_lock,
  output logic thermal_lock,
  output logic restart_off
);
  import switch_ctrl_pkg::*;

  localparam logic [AR_W-1:0] AR_ON_LAST = AR_W'(AR_ON_CYCLES - 1);
  localparam logic [AR_W-1:0] AR_OFF_LAST = AR_W'(AR_OFF_CYCLES - 1);

  logic cycle_start;
  logic fb_en_q;
  logic gate_q;
  logic gate_d;
  logic charge_q;
  logic uv_lock_q;
  logic ot_lock_q;
  logic [5:0] blank_q;
  logic [AR_W-1:0] ar_cnt_q;
  restart_state_t ar_state_q;
  logic any_lock;
  logic start_ok;
  logic limit_hit;

  // ----------------------------------------------------------------
  // Oscillator
  // ----------------------------------------------------------------
  cycle_oscillator u_osc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cycle_start(cycle_start),
    .max_duty_window(max_duty_window)
  );

  // ----------------------------------------------------------------
  // Feedback sense
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fb_en_q <= 1'b0;
    end else begin
      fb_en_q <= !feedback_over_threshold;
    end
  end

  // ----------------------------------------------------------------
  // Protection latches
  // ----------------------------------------------------------------
  // Locked out from power-on until the supply is seen restored
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      uv_lock_q <= 1'b1;
    end else if (prot_flags.supply_low) begin
      uv_lock_q <= 1'b1;
    end else if (prot_flags.supply_restored) begin
      uv_lock_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ot_lock_q <= 1'b0;
    end else if (prot_flags.temp_hot) begin
      ot_lock_q <= 1'b1;
    end else if (prot_flags.temp_cooled) begin
      ot_lock_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Auto-restart
  // ----------------------------------------------------------------
  // The off phase runs its full length even if feedback returns meanwhile
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ar_state_q <= AR_RUN;
      ar_cnt_q <= '0;
    end else begin
      unique case (ar_state_q)
        AR_RUN: begin
          if (fb_en_q) begin
            ar_cnt_q <= '0;
          end else if (cycle_start) begin
            if (ar_cnt_q == AR_ON_LAST) begin
              ar_state_q <= AR_OFF;
              ar_cnt_q <= '0;
            end else begin
              ar_cnt_q <= ar_cnt_q + AR_W'(1);
            end
          end
        end
        AR_OFF: begin
          if (cycle_start) begin
            if (ar_cnt_q == AR_OFF_LAST) begin
              ar_state_q <= AR_RUN;
              ar_cnt_q <= '0;
            end else begin
              ar_cnt_q <= ar_cnt_q + AR_W'(1);
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Switch gate
  // ----------------------------------------------------------------
  assign any_lock = uv_lock_q || ot_lock_q || (ar_state_q != AR_RUN);
  // Enable looked at only here, so later changes in the cycle have no effect
  assign start_ok = cycle_start && fb_en_q && !any_lock;
  assign limit_hit = current_limit && (blank_q == 6'h00);

  always_comb begin
    gate_d = gate_q;
    if (gate_q && (!max_duty_window || limit_hit || any_lock)) begin
      gate_d = 1'b0;
    end
    if (start_ok) begin
      gate_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_q <= 1'b0;
      charge_q <= 1'b1;
    end else begin
      gate_q <= gate_d;
      charge_q <= !gate_d;
    end
  end

  // Blanking restarts at each turn-on; spikes before it ends are ignored
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      blank_q <= 6'h00;
    end else if (start_ok) begin
      blank_q <= TURN_ON_BLANKING_CYCLES;
    end else if (blank_q != 6'h00) begin
      blank_q <= blank_q - 6'h01;
    end
  end

  assign feedback_enable = fb_en_q;
  assign power_switch_on = gate_q;
  assign supply_charge_en = charge_q;
  assign undervoltage_lock = uv_lock_q;
  assign thermal_lock = ot_lock_q;
  assign restart_off = (ar_state_q == AR_OFF);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_fb_sense: assert property (@(posedge sys_clk) disable iff (!reset_n)
    feedback_over_threshold |=> !feedback_enable)
    else $error("feedback enable high above threshold");
  chk_start_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
    start_ok |=> power_switch_on && !supply_charge_en)
    else $error("enabled cycle did not turn the switch on");
  chk_start_skip: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cycle_start && !fb_en_q |=> !power_switch_on)
    else $error("disabled cycle turned the switch on");
  chk_no_midcycle_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(power_switch_on) |-> $past(cycle_start) && $past(fb_en_q))
    else $error("switch turned on outside cycle start");
  chk_window_end: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_switch_on && !max_duty_window |=> !power_switch_on)
    else $error("pulse ran past max duty window");
  chk_limit_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_switch_on && limit_hit && !cycle_start |=> !power_switch_on [*2])
    else $error("current limit did not end the pulse");
  chk_blank_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    start_ok ##1 (current_limit && max_duty_window && !any_lock) [*3]
    |-> power_switch_on)
    else $error("current limit acted during blanking");
  chk_uv_lock: assert property (@(posedge sys_clk) disable iff (!reset_n)
    prot_flags.supply_low |=> undervoltage_lock ##1 !power_switch_on)
    else $error("under-voltage did not lock switching");
  chk_uv_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    undervoltage_lock && !prot_flags.supply_restored |=> undervoltage_lock)
    else $error("under-voltage lock released early");
  chk_ot_lock: assert property (@(posedge sys_clk) disable iff (!reset_n)
    prot_flags.temp_hot |=> thermal_lock ##1 !power_switch_on)
    else $error("thermal flag did not stop switching");
  chk_ar_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fb_en_q && ar_state_q == AR_RUN |=> ar_cnt_q == '0)
    else $error("restart counter not cleared by feedback");
  chk_ar_enter: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ar_state_q == AR_RUN && cycle_start && !fb_en_q && ar_cnt_q == AR_ON_LAST
    |=> restart_off ##1 !power_switch_on)
    else $error("restart off phase not entered");
  chk_ar_leave: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ar_state_q == AR_OFF && cycle_start && ar_cnt_q == AR_OFF_LAST |=> !restart_off)
    else $error("restart off phase did not end");
  chk_charge: assert property (@(posedge sys_clk) disable iff (!reset_n)
    supply_charge_en != power_switch_on)
    else $error("charging while switch conducts");

  cov_pulse_window: cover property (@(posedge sys_clk) disable iff (!reset_n)
    power_switch_on ##1 !max_duty_window ##1 !power_switch_on);
  cov_pulse_limit: cover property (@(posedge sys_clk) disable iff (!reset_n)
    power_switch_on && limit_hit && max_duty_window);
  cov_restart: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(restart_off));

endmodule
`default_nettype wire

/* hw/switch_ctrl_pkg.sv */
// Shared constants and carrier types for the on/off switch cycle controller.
// Assumes a 100 MHz system clock; all times are turned into cycle counts here.
package switch_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and oscillator timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 200_000;
  localparam int unsigned JITTER_PP_HZ = 16_000;
  localparam int unsigned JITTER_MOD_HZ = 1_500;

  localparam int unsigned PER_W = 10;
  localparam logic [PER_W-1:0] PERIOD_NOM = PER_W'(CLK_HZ / OSC_HZ);
  localparam logic [PER_W-1:0] PERIOD_FAST = PER_W'(CLK_HZ / (OSC_HZ + JITTER_PP_HZ / 2));
  localparam logic [PER_W-1:0] PERIOD_SLOW = PER_W'(CLK_HZ / (OSC_HZ - JITTER_PP_HZ / 2));
  localparam logic [PER_W-1:0] JIT_SPAN = PERIOD_SLOW - PERIOD_FAST;
  // Half a modulation period is shared out evenly over the span
  localparam int unsigned MOD_HALF_CYCLES = CLK_HZ / (2 * JITTER_MOD_HZ);
  localparam logic [15:0] JIT_STEP_CYCLES = 16'(MOD_HALF_CYCLES / JIT_SPAN);

  // ----------------------------------------------------------------
  // Duty window and blanking (least time rounds up, longest down)
  // ----------------------------------------------------------------
  localparam int unsigned MAX_DUTY_TIME_NS = 3250;
  localparam logic [PER_W-1:0] MAX_DUTY_CYCLES = PER_W'(MAX_DUTY_TIME_NS / CLK_PERIOD_NS);
  localparam int unsigned TURN_ON_BLANKING_TIME_NS = 220;
  localparam logic [5:0] TURN_ON_BLANKING_CYCLES =
    6'((TURN_ON_BLANKING_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Auto-restart, counted in nominal oscillator cycles
  // ----------------------------------------------------------------
  localparam int unsigned AR_W = 18;
  localparam int unsigned AR_ON_TIME_MS = 30;
  localparam int unsigned AR_OFF_TIME_MS = 650;
  localparam int unsigned AR_ON_CYCLES_NOM = AR_ON_TIME_MS * (OSC_HZ / 1000);
  localparam int unsigned AR_OFF_CYCLES_NOM = AR_OFF_TIME_MS * (OSC_HZ / 1000);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    AR_RUN = 1'b0,
    AR_OFF = 1'b1
  } restart_state_t;

  typedef struct packed {
    logic supply_low;
    logic supply_restored;
    logic temp_hot;
    logic temp_cooled;
  } protect_flags_t;

endpackage

/* sim/switch_plant_model.sv */
// Far side model: optocoupler feedback path and switch current ramp.
// Assumes bench-side inputs change at the falling edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module switch_plant_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic power_switch_on,
  input wire logic load_demand,
  input wire logic [9:0] limit_delay,
  output logic feedback_over_threshold,
  output logic current_limit
);
  logic [9:0] ramp_q;
  // Output under target: opto dark, feedback current below threshold
  assign feedback_over_threshold = !load_demand;
  // Ramp restarts each turn-on, so the limit comes a set time into conduction
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp_q <= 10'h000;
    end else if (power_switch_on) begin
      ramp_q <= ramp_q + 10'h001;
    end else begin
      ramp_q <= 10'h000;
    end
  end
  // Comparator idles low once the switch is off
  assign current_limit = power_switch_on && (ramp_q >= limit_delay);
endmodule
`default_nettype wire

/* sim/test_on_off_switch_cycle_controller.sv */
// Self-checking bench for the on/off switch cycle controller.
// Assumes switch_plant_model as far side and restart counts shortened to 4 and 8.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_on_off_switch_cycle_controller;
  import switch_ctrl_pkg::*;
  typedef struct {logic dem; logic flip; logic [9:0] lim; int lo; int hi;} row_t;
  logic sys_clk, reset_n, load_demand, fb_over, cur_lim, power_switch_on;
  logic supply_charge_en, max_duty_window, undervoltage_lock, thermal_lock, restart_off;
  logic charge_bad, at_rise, fb_en;
  logic [9:0] limit_delay;
  protect_flags_t prot_flags;
  int err_total, n_compared, width, per, starts, wsum, win;
  int min_per = 1000;
  int max_per = 0;
  row_t rows[7] = '{'{1'b1, 1'b0, 10'h3ff, 324, 326}, '{1'b0, 1'b0, 10'h3ff, 0, 0},
    '{1'b1, 1'b0, 10'h032, 50, 53}, '{1'b0, 1'b1, 10'h3ff, 0, 0},
    '{1'b1, 1'b1, 10'h3ff, 324, 326}, '{1'b1, 1'b0, 10'h000, 22, 25},
    '{1'b1, 1'b0, 10'h01e, 30, 33}};

  on_off_switch_cycle_controller #(.AR_ON_CYCLES(4), .AR_OFF_CYCLES(8))
    u_on_off_switch_cycle_controller (.sys_clk(sys_clk), .reset_n(reset_n),
    .feedback_over_threshold(fb_over), .current_limit(cur_lim), .prot_flags(prot_flags),
    .feedback_enable(fb_en), .power_switch_on(power_switch_on),
    .supply_charge_en(supply_charge_en), .max_duty_window(max_duty_window),
    .undervoltage_lock(undervoltage_lock), .thermal_lock(thermal_lock),
    .restart_off(restart_off));
  switch_plant_model u_switch_plant_model (.sys_clk(sys_clk), .reset_n(reset_n),
    .power_switch_on(power_switch_on), .load_demand(load_demand),
    .limit_delay(limit_delay), .feedback_over_threshold(fb_over), .current_limit(cur_lim));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----
  // Tasks
  // ----
  task automatic give_verdict();
    $display("TB: %0d compared, %0d mismatched", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Runs to the next window rise, counting conducting cycles on the way
  task automatic run_period(input logic flip);
    logic prev;
    prev = 1'b1;
    per = 0;
    width = 0;
    win = 0;
    charge_bad = 1'b0;
    while (per < 600 && !(max_duty_window === 1'b1 && prev === 1'b0)) begin
      prev = max_duty_window;
      @(negedge sys_clk);
      per++;
      if (power_switch_on === 1'b1) width++;
      if (max_duty_window === 1'b1) win++;
      if (supply_charge_en !== !power_switch_on) charge_bad = 1'b1;
      if (flip && per == 10) load_demand = !load_demand;
    end
    if (per >= 600) begin
      err_total++;
      $display("TB: no cycle start seen");
    end else if (at_rise) begin
      if (per < min_per) min_per = per;
      if (per > max_per) max_per = per;
    end
    at_rise = 1'b1;
  endtask

  task automatic wait_off(input logic lvl);
    starts = 0;
    wsum = 0;
    while (restart_off !== lvl && starts < 12) begin
      run_period(1'b0);
      starts++;
      wsum += width;
    end
  endtask

  // Set flag cuts a live pulse; only the release flag ends the lock
  task automatic lock_case(input int set_b, input int clr_b, input logic uv);
    load_demand = 1'b1;
    limit_delay = 10'h3ff;
    run_period(1'b0);
    repeat (40) @(negedge sys_clk);
    at_rise = 1'b0;
    `CHK("conducting", 1'b1, power_switch_on)
    prot_flags[set_b] = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK("lock set", 1'b1, uv ? undervoltage_lock : thermal_lock)
    `CHK("pulse cut", 1'b0, power_switch_on)
    prot_flags[set_b] = 1'b0;
    run_period(1'b0);
    run_period(1'b0);
    `CHK("held off", 0, width)
    prot_flags[clr_b] = 1'b1;
    @(negedge sys_clk);
    prot_flags[clr_b] = 1'b0;
    // Next period is entered one edge late, so it is not timed
    at_rise = 1'b0;
    run_period(1'b0);
    run_period(1'b0);
    `CHK("resumed", 1'b1, width > 0)
    $display("TB: protection case %0d done", set_b);
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    err_total = 0;
    n_compared = 0;
    reset_n = 1'b0;
    load_demand = 1'b1;
    limit_delay = 10'h3ff;
    prot_flags = '0;
    at_rise = 1'b0;
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    `CHK("uv lock at reset", 1'b1, undervoltage_lock)
    `CHK("charging at reset", 1'b1, supply_charge_en)
    `CHK("restart idle", 1'b0, restart_off)
    `CHK("fb enable at release", 1'b1, fb_en)
    run_period(1'b0);
    run_period(1'b0);
    `CHK("no pulse before supply up", 0, width)
    prot_flags.supply_restored = 1'b1;
    @(negedge sys_clk);
    prot_flags.supply_restored = 1'b0;
    at_rise = 1'b0;
    $display("TB: reset test done");
    foreach (rows[i]) begin
      load_demand = rows[i].dem;
      limit_delay = rows[i].lim;
      run_period(1'b0);
      run_period(rows[i].flip);
      `CHK("pulse width", 1'b1, width >= rows[i].lo && width <= rows[i].hi)
      `CHK("charge opposes switch", 1'b0, charge_bad)
      `CHK("window length", int'(MAX_DUTY_CYCLES), win)
      `CHK("feedback sense", rows[i].dem ^ rows[i].flip, fb_en)
      $display("TB: row %0d done, width %0d", i, width);
    end
    lock_case(3, 2, 1'b1);
    lock_case(1, 0, 1'b0);
    load_demand = 1'b0;
    wait_off(1'b1);
    `CHK("restart entry", 1'b1, starts >= 3 && starts <= 6)
    wait_off(1'b0);
    `CHK("off span", 1'b1, starts >= 7 && starts <= 9)
    `CHK("silent off", 0, wsum)
    wait_off(1'b1);
    `CHK("restart repeats", 1'b1, starts >= 3 && starts <= 6)
    load_demand = 1'b1;
    wait_off(1'b0);
    `CHK("off kept", 1'b1, starts >= 7 && starts <= 9)
    `CHK("silent off kept", 0, wsum)
    run_period(1'b0);
    run_period(1'b0);
    `CHK("switching resumes", 1'b1, width > 0)
    $display("TB: restart test done");
    `CHK("period spread", 1'b1, min_per >= 480 && max_per <= 520 && max_per > min_per + 1)
    // Reset dropped into a live pulse must cut it at once
    run_period(1'b0);
    repeat (40) @(negedge sys_clk);
    `CHK("conducting before reset", 1'b1, power_switch_on)
    reset_n = 1'b0;
    @(negedge sys_clk);
    `CHK("switch off in reset", 1'b0, power_switch_on)
    `CHK("charging in reset", 1'b1, supply_charge_en)
    `CHK("uv lock in reset", 1'b1, undervoltage_lock)
    reset_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK("uv lock after reset", 1'b1, undervoltage_lock)
    `CHK("fb enable after reset", 1'b1, fb_en)
    `CHK("restart idle after reset", 1'b0, restart_off)
    `CHK("switch off after reset", 1'b0, power_switch_on)
    $display("TB: mid-run reset test done");
    give_verdict();
  end

  // Whole run needs about 30000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    $display("TB: watchdog expired");
    give_verdict();
  end
endmodule
`default_nettype wire
